//--- logic/mvi_pkg.sv
// ============================================================================
// Package for the multilevel vectored interrupt controller
// ============================================================================
// Holds the source map, levels, register offsets, fields and reset values.
// Assumes a single 20 MHz system clock domain with synchronous reset.
package mvi_pkg;

    // ========================================================================
    // Source and vector map
    // ========================================================================
    localparam int NUM_SRC = 29;
    localparam int NUM_VEC = 10;
    // First source index of each vector; entry NUM_VEC closes the last range
    localparam int VEC_FIRST_SRC [0:10] = '{0, 1, 2, 5, 9, 11, 14, 17, 21, 25, 29};
    // Named sources; only SRC_EXT_IRQ_THREE is used by the block's own logic
    localparam int SRC_EXT_IRQ_THREE = 5;
    localparam int SRC_BASE_TIMER_A  = 7;  // Two base-timer events stay apart
    localparam int SRC_BASE_TIMER_B  = 8;
    localparam int SRC_PWM_PAIR_HI   = 24; // Combined upper PWM pair
    localparam int SRC_PWM_PAIR_LO   = 28; // Combined lower PWM pair
    // Number of vectors that may take the top level
    localparam int NUM_TOP_VEC       = 2;

    // Vector address = base + step * index
    localparam logic [16:0] VEC_ADDR_BASE = 17'h00003;
    localparam logic [16:0] VEC_ADDR_STEP = 17'h00008;

    // ========================================================================
    // Priority levels
    // ========================================================================
    localparam logic [1:0] LVL_NONE = 2'h0;
    localparam logic [1:0] LVL_LOW  = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    localparam logic [1:0] LVL_TOP  = 2'h3;

    // ========================================================================
    // Register map (byte addresses)
    // ========================================================================
    localparam logic [7:0] OFS_LEVEL   = 8'h00;
    localparam logic [7:0] OFS_ENABLE  = 8'h04;
    localparam logic [7:0] OFS_PEND    = 8'h08;
    localparam logic [7:0] OFS_FILTER  = 8'h0C;
    localparam logic [7:0] OFS_SERVICE = 8'h10;
    localparam logic [7:0] OFS_PIN     = 8'h14;

    // Reset values
    localparam logic [9:0]  LEVEL_RST  = 10'h000;
    localparam logic [28:0] ENABLE_RST = 29'h00000000;
    localparam logic [4:0]  FILTER_RST = 5'h00;

    // Filter register fields
    localparam int FILT_TC_LSB    = 0;
    localparam int FILT_EXT3_BIT  = 2;
    localparam int FILT_TIN_BIT   = 3;
    localparam int FILT_T0CP_BIT  = 4;
    // Service register fields
    localparam int SVC_MASK_LSB   = 0;
    localparam int SVC_CUR_LSB    = 4;
    localparam int SVC_VEC_LSB    = 8;

    // Filter time constant codes
    localparam logic [1:0] FTC_OFF = 2'h0;
    localparam logic [1:0] FTC_1   = 2'h1;
    localparam logic [1:0] FTC_32  = 2'h2;
    localparam logic [1:0] FTC_128 = 2'h3;
    // Time constants in instruction cycles
    localparam int TC_SHORT_INSTR = 1;
    localparam int TC_MID_INSTR   = 32;
    localparam int TC_LONG_INSTR  = 128;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- logic/mvi_noise_filter.sv
// ============================================================================
// Noise filter for the remote-control input
// ============================================================================
// Output follows the input once it has held a new level for limit_cyc clocks.
// Assumes raw_level is already synchronised to sys_clk.
module mvi_noise_filter #(
    parameter int CNT_W = 8
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    // Filter input and setting
    input  wire logic             raw_level,
    input  wire logic [CNT_W-1:0] limit_cyc,
    // Filtered level
    output logic                  filt_level
);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             filt_q;
    logic             filt_d;

    initial begin
        if (CNT_W < 1) $error("mvi_noise_filter: CNT_W must be at least 1");
    end

    // ========================================================================
    // Stability counter
    // ========================================================================
    // Any return to the old level restarts the count, so spikes are dropped
    always_comb begin
        cnt_d  = '0;
        filt_d = filt_q;
        if (raw_level != filt_q) begin
            if (cnt_q + CNT_W'(1) >= limit_cyc) begin
                filt_d = raw_level;
            end else begin
                cnt_d = cnt_q + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt_q  <= '0;
            filt_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            filt_q <= filt_d;
        end
    end

    assign filt_level = filt_q;

endmodule

//--- logic/mvi_ctrl.sv
// ============================================================================
// Multilevel vectored interrupt controller
// ============================================================================
// Gathers 29 sources on 10 vectors with three levels, plus the remote pin
// filter. Assumes an AXI4-Lite master, same-clock source pulses and a CPU
// that acknowledges a request and signals each return from service.
//
// Operation
// - 29 sources onto 10 vectors from lowest
// - Three levels: top over high over low
// - Refuse requests at or below serviced level
// - Simultaneous requests: highest level wins first
// - Equal level: smallest vector address wins
// - Vectors 0-1 top/low, others high/low
// - Base timers separate; PWM pairs combined sources
// - Filter constant of 1, 32, 128 cycles
// - Filter for ext3/timer inputs; pin reads raw
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
module mvi_ctrl
    import mvi_pkg::*;
#(
    parameter int CYC_PER_INSTR = 1,
    parameter int ADDR_W        = 8
) (
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    // AXI4-Lite write address and data
    input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0]      s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // Interrupt sources (one-cycle pulses)
    input  wire logic [mvi_pkg::NUM_SRC-1:0] src_evt,
    // Remote-control pin and its timer outputs
    input  wire logic                   remote_input_pin,
    output logic                        timer_zero_input,
    output logic                        timer_zero_capture_input,
    // CPU side
    output logic                        irq_req,
    output logic [3:0]                  irq_vec_idx,
    output logic [16:0]                 irq_vec_addr,
    output logic [1:0]                  irq_level,
    input  wire logic                   irq_ack,
    input  wire logic                   irq_return
);

    localparam int FCNT_W = 16;
    // Filter counts in sys_clk cycles derived from instruction cycles
    localparam int TC_SHORT_CYC = TC_SHORT_INSTR * CYC_PER_INSTR;
    localparam int TC_MID_CYC   = TC_MID_INSTR * CYC_PER_INSTR;
    localparam int TC_LONG_CYC  = TC_LONG_INSTR * CYC_PER_INSTR;

    initial begin
        if (CYC_PER_INSTR < 1 || TC_LONG_CYC >= (1 << FCNT_W))
            $error("mvi_ctrl: CYC_PER_INSTR out of range");
        if (ADDR_W < 8 || ADDR_W > 32)
            $error("mvi_ctrl: ADDR_W must be 8 to 32");
    end

    // ========================================================================
    // Helper functions
    // ========================================================================
    // Byte-lane merge of a bus write
    function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) res[b*8 +: 8] = new_v[b*8 +: 8];
        end
        return res;
    endfunction

    // Level a vector runs at from its select bit
    function automatic logic [1:0] vec_level(input int idx, input logic sel);
        if (!sel) return LVL_LOW;
        else if (idx < NUM_TOP_VEC) return LVL_TOP;
        else return LVL_HIGH;
    endfunction

    // Highest level held in a service mask (bit n = level n+1)
    function automatic logic [1:0] top_level(input logic [2:0] mask);
        if (mask[2]) return LVL_TOP;
        else if (mask[1]) return LVL_HIGH;
        else if (mask[0]) return LVL_LOW;
        else return LVL_NONE;
    endfunction

    // ========================================================================
    // State
    // ========================================================================
    logic [9:0]          level_q, level_d;
    logic [NUM_SRC-1:0]  enable_q, enable_d;
    logic [NUM_SRC-1:0]  pend_q, pend_d;
    logic [4:0]          filter_q, filter_d;
    logic [2:0]          svc_q, svc_d;
    logic                aw_held_q, aw_held_d;
    logic [ADDR_W-1:0]   aw_addr_q, aw_addr_d;
    logic                w_held_q, w_held_d;
    logic [31:0]         w_data_q, w_data_d;
    logic [3:0]          w_strb_q, w_strb_d;
    logic                bvalid_q, bvalid_d;
    logic [1:0]          bresp_q, bresp_d;
    logic                rvalid_q, rvalid_d;
    logic [31:0]         rdata_q, rdata_d;
    logic [1:0]          rresp_q, rresp_d;
    logic                req_q, req_d;
    logic [3:0]          vec_q, vec_d;
    logic [1:0]          lvl_q, lvl_d;
    logic                pin_s1_q, pin_s2_q;
    logic                ext3_prev_q;
    logic                tin_q, t0cp_q;
    logic                filt_level;
    logic [FCNT_W-1:0]   filt_limit;
    logic                ext3_level;
    logic                do_write;
    logic [NUM_SRC-1:0]  src_set;
    logic [NUM_VEC-1:0]  vec_pend;

    // ========================================================================
    // Remote pin: synchroniser and filter
    // ========================================================================
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
        end else begin
            pin_s1_q <= remote_input_pin;
            pin_s2_q <= pin_s1_q;
        end
    end

    // Time constant select
    always_comb begin
        case (filter_q[FILT_TC_LSB +: 2])
            FTC_32:  filt_limit = FCNT_W'(TC_MID_CYC);
            FTC_128: filt_limit = FCNT_W'(TC_LONG_CYC);
            default: filt_limit = FCNT_W'(TC_SHORT_CYC);
        endcase
    end

    mvi_noise_filter #(
        .CNT_W      (FCNT_W)
    ) u_filter (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .raw_level  (pin_s2_q),
        .limit_cyc  (filt_limit),
        .filt_level (filt_level)
    );

    // Each consumer picks filtered or raw; code OFF bypasses for all
    function automatic logic pick_level(input logic use_f);
        return (use_f && filter_q[FILT_TC_LSB +: 2] != FTC_OFF) ? filt_level : pin_s2_q;
    endfunction

    always_comb ext3_level = pick_level(filter_q[FILT_EXT3_BIT]);

    // Timer outputs registered; ext3 edge taken on a rising level
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ext3_prev_q <= 1'b0;
            tin_q       <= 1'b0;
            t0cp_q      <= 1'b0;
        end else begin
            ext3_prev_q <= ext3_level;
            tin_q       <= pick_level(filter_q[FILT_TIN_BIT]);
            t0cp_q      <= pick_level(filter_q[FILT_T0CP_BIT]);
        end
    end

    assign timer_zero_input         = tin_q;
    assign timer_zero_capture_input = t0cp_q;

    // ========================================================================
    // Pending flags
    // ========================================================================
    // Each source bit is its own flag: base timers apart, PWM pairs one bit
    always_comb begin
        src_set = src_evt;
        src_set[SRC_EXT_IRQ_THREE] = src_evt[SRC_EXT_IRQ_THREE] | (ext3_level & ~ext3_prev_q);
        src_set = src_set & enable_q;
    end

    // Per-vector OR over its source range
    always_comb begin
        for (int v = 0; v < NUM_VEC; v++) begin
            vec_pend[v] = 1'b0;
            for (int s = VEC_FIRST_SRC[v]; s < VEC_FIRST_SRC[v+1]; s++) begin
                vec_pend[v] = vec_pend[v] | (pend_q[s] & enable_q[s]);
            end
        end
    end

    // ========================================================================
    // AXI4-Lite slave
    // ========================================================================
    // Address and data latched separately so either may come first
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign do_write      = aw_held_q && w_held_q && !bvalid_q;

    // Write channel and register next values
    always_comb begin
        aw_held_d = aw_held_q;
        aw_addr_d = aw_addr_q;
        w_held_d  = w_held_q;
        w_data_d  = w_data_q;
        w_strb_d  = w_strb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        level_d   = level_q;
        enable_d  = enable_q;
        filter_d  = filter_q;
        pend_d    = pend_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_d = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb_d = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) bvalid_d = 1'b0;
        if (do_write) begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = RESP_OKAY;
            case (aw_addr_q[7:0])
                OFS_LEVEL:   level_d  = 10'(merge_strb({22'h0, level_q}, w_data_q, w_strb_q));
                OFS_ENABLE:  enable_d = 29'(merge_strb({3'h0, enable_q}, w_data_q, w_strb_q));
                OFS_FILTER:  filter_d = 5'(merge_strb({27'h0, filter_q}, w_data_q, w_strb_q));
                // Write one to clear
                OFS_PEND:    pend_d   = pend_q & ~29'(merge_strb(32'h0, w_data_q, w_strb_q));
                OFS_SERVICE: ;
                OFS_PIN:     ;
                default:     bresp_d  = RESP_SLVERR;
            endcase
            if ((aw_addr_q >> 8) != '0) bresp_d = RESP_SLVERR;
        end
        // New events set after the clear so a same-cycle event survives
        pend_d = pend_d | src_set;
    end

    // Read channel: answer one cycle after address is taken
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (s_axi_rvalid && s_axi_rready) rvalid_d = 1'b0;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d  = RESP_OKAY;
            rdata_d  = 32'h0;
            case (s_axi_araddr[7:0])
                OFS_LEVEL:   rdata_d[9:0]  = level_q;
                OFS_ENABLE:  rdata_d[28:0] = enable_q;
                OFS_PEND:    rdata_d[28:0] = pend_q;
                OFS_FILTER:  rdata_d[4:0]  = filter_q;
                OFS_SERVICE: begin
                    rdata_d[SVC_MASK_LSB +: 3] = svc_q;
                    rdata_d[SVC_CUR_LSB +: 2]  = top_level(svc_q);
                    rdata_d[SVC_VEC_LSB +: 4]  = vec_q;
                end
                OFS_PIN:     rdata_d[0]    = pin_s2_q;   // Raw level always
                default:     rresp_d       = RESP_SLVERR;
            endcase
            if ((s_axi_araddr >> 8) != '0) rresp_d = RESP_SLVERR;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

    // ========================================================================
    // Service stack and arbitration
    // ========================================================================
    // Return pops the highest level first, then an ack pushes its level
    always_comb begin
        svc_d = svc_q;
        if (irq_return) begin
            if (svc_d[2]) svc_d[2] = 1'b0;
            else if (svc_d[1]) svc_d[1] = 1'b0;
            else svc_d[0] = 1'b0;
        end
        if (irq_ack && req_q && lvl_q != LVL_NONE) begin
            svc_d[lvl_q - 2'h1] = 1'b1;
        end
    end

    // Arbitrate against the next service level so no stale request appears
    always_comb begin
        logic [1:0] cur;
        logic       found;
        cur   = top_level(svc_d);
        found = 1'b0;
        req_d = 1'b0;
        vec_d = vec_q;
        lvl_d = LVL_NONE;
        // Scan levels top first, vectors lowest address first
        for (int l = 3; l >= 1; l--) begin
            for (int v = 0; v < NUM_VEC; v++) begin
                if (!found && vec_pend[v] && vec_level(v, level_q[v]) == 2'(l)
                    && 2'(l) > cur) begin
                    found = 1'b1;
                    req_d = 1'b1;
                    vec_d = 4'(v);
                    lvl_d = 2'(l);
                end
            end
        end
    end

    assign irq_req      = req_q;
    assign irq_vec_idx  = vec_q;
    assign irq_level    = lvl_q;
    assign irq_vec_addr = VEC_ADDR_BASE + 17'(VEC_ADDR_STEP * vec_q);

    // ========================================================================
    // Registers
    // ========================================================================
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            level_q   <= LEVEL_RST;
            enable_q  <= ENABLE_RST;
            pend_q    <= '0;
            filter_q  <= FILTER_RST;
            svc_q     <= 3'h0;
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
            w_held_q  <= 1'b0;
            w_data_q  <= 32'h0;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0;
            rresp_q   <= RESP_OKAY;
            req_q     <= 1'b0;
            vec_q     <= 4'h0;
            lvl_q     <= LVL_NONE;
        end else begin
            level_q   <= level_d;
            enable_q  <= enable_d;
            pend_q    <= pend_d;
            filter_q  <= filter_d;
            svc_q     <= svc_d;
            aw_held_q <= aw_held_d;
            aw_addr_q <= aw_addr_d;
            w_held_q  <= w_held_d;
            w_data_q  <= w_data_d;
            w_strb_q  <= w_strb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
            req_q     <= req_d;
            vec_q     <= vec_d;
            lvl_q     <= lvl_d;
        end
    end

endmodule

//--- verification/mvi_cpu_model.sv
// ======================================
// CPU-side partner model for mvi_ctrl
// ======================================
// Acks a pending request when allowed; returns when the bench commands it.
module mvi_cpu_model (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // Controller side and bench commands
    input  wire logic irq_req,
    input  wire logic take_en,
    input  wire logic do_ret,
    output logic      irq_ack,
    output logic      irq_return
);
    timeunit 1ns;
    timeprecision 1ns;
    // One-cycle pulses; no back-to-back ack, so arbitration settles first
    always_ff @(posedge sys_clk) begin
        irq_ack    <= rst_n && take_en && irq_req && !irq_ack;
        irq_return <= rst_n && do_ret;
    end
endmodule

//--- verification/mvi_ctrl_props.sv
// ======================================
// Port checker for mvi_ctrl
// ======================================
// Sees only top-level ports; bound to every mvi_ctrl below.
module mvi_ctrl_props
    import mvi_pkg::*;
(
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // Read channel
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // CPU side
    input wire logic        irq_req,
    input wire logic [3:0]  irq_vec_idx,
    input wire logic [16:0] irq_vec_addr,
    input wire logic [1:0]  irq_level,
    input wire logic        irq_ack,
    input wire logic        irq_return
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    vec_addr_a:
        assert property (irq_req |-> irq_vec_addr == VEC_ADDR_BASE + VEC_ADDR_STEP * irq_vec_idx)
        else $error("vector address off");
    vec_range_a:
        assert property (irq_req |-> irq_vec_idx < 4'hA) else $error("vector out of range");
    req_level_a:
        assert property (irq_req |-> irq_level != LVL_NONE) else $error("request without level");
    nest_refuse_a:
        assert property (irq_req && irq_ack && !irq_return |=>
            !irq_req || irq_level > $past(irq_level)) else $error("nested level not above");
    top_pair_a:
        assert property (irq_req && irq_vec_idx > 4'h1 |-> irq_level != LVL_TOP)
        else $error("top level on upper vector");
    low_pair_a:
        assert property (irq_req && irq_vec_idx < 4'h2 |-> irq_level != LVL_HIGH)
        else $error("high level on lower vector");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
endmodule

bind mvi_ctrl mvi_ctrl_props u_props (.sys_clk(sys_clk), .rst_n(rst_n),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .irq_req(irq_req), .irq_vec_idx(irq_vec_idx), .irq_vec_addr(irq_vec_addr),
    .irq_level(irq_level), .irq_ack(irq_ack), .irq_return(irq_return));

//--- verification/mvi_ctrl_tb.sv
// ======================================
// Testbench for mvi_ctrl
// ======================================
// AXI4-Lite tasks, source pulses, pin drive; CPU model takes requests.
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin err_total++; \
    $display("unexpected %s exp %0h got %0h", nm, ex, got); end end
module mvi_ctrl_tb
    import mvi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 0, rst_n = 0, awv = 0, wv = 0, brd = 0, arv = 0, rrd = 0;
    logic pin = 0, take_en = 0, do_ret = 0, ta, tw;
    logic [7:0] awa = '0, ara = '0;
    logic [31:0] wd = '0, rd, rdata;
    logic [28:0] evt = '0;
    logic [1:0] rsp, bresp, rresp, lvl;
    logic [3:0] idx;
    logic [16:0] vaddr;
    logic awr, wr_, bv, arr, rv, req, ack, ret, tin, t0cp;
    int err_total = 0, samples_checked = 0;
    int srcs [4] = '{7, 8, 24, 28};
    // 20 MHz clock
    always #25 sys_clk = ~sys_clk;
    mvi_ctrl u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wr_), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brd),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrd), .src_evt(evt),
        .remote_input_pin(pin), .timer_zero_input(tin), .timer_zero_capture_input(t0cp),
        .irq_req(req), .irq_vec_idx(idx), .irq_vec_addr(vaddr), .irq_level(lvl),
        .irq_ack(ack), .irq_return(ret));
    mvi_cpu_model u_cpu (.sys_clk(sys_clk), .rst_n(rst_n), .irq_req(req), .take_en(take_en),
        .do_ret(do_ret), .irq_ack(ack), .irq_return(ret));
    // Ready is sampled at the falling edge, where it is settled
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {ta, tw} = 2'h0;
        awa <= a;
        wd <= d;
        {awv, wv} <= 2'h3;
        while (!(ta && tw)) begin
            @(negedge sys_clk);
            if (awv && awr) ta = 1;
            if (wv && wr_) tw = 1;
            @(posedge sys_clk);
            if (ta) awv <= 0;
            if (tw) wv <= 0;
        end
        brd <= 1;
        do @(negedge sys_clk); while (!bv);
        rsp = bresp;
        @(posedge sys_clk);
        brd <= 0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge sys_clk);
        ara <= a;
        arv <= 1;
        do @(negedge sys_clk); while (!arr);
        @(posedge sys_clk);
        arv <= 0;
        @(posedge sys_clk);
        rrd <= 1;
        do @(negedge sys_clk); while (!rv);
        rd = rdata;
        rsp = rresp;
        @(posedge sys_clk);
        rrd <= 0;
    endtask
    // Source pulse, then settle past the request update
    task automatic fire(input logic [28:0] m);
        @(posedge sys_clk);
        evt <= m;
        @(posedge sys_clk);
        evt <= '0;
        @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    // CPU model command: r=1 return, r=0 take the request
    task automatic cpu(input logic r);
        @(posedge sys_clk);
        {do_ret, take_en} <= {r, !r};
        @(posedge sys_clk);
        {do_ret, take_en} <= 2'h0;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1;
        rd_reg(OFS_ENABLE);
        `CHK("enable", 32'h0, rd)
        rd_reg(8'h18);
        `CHK("rd resp", RESP_SLVERR, rsp)
        wr(8'h1C, 32'h0);
        `CHK("wr resp", RESP_SLVERR, rsp)
        wr(OFS_ENABLE, 32'h1FFFFFFF);
        `CHK("wr resp", RESP_OKAY, rsp)
        fire(29'h208);
        `CHK("vec", 4'h2, idx)
        `CHK("addr", 17'h00013, vaddr)
        wr(OFS_LEVEL, 32'h10);
        @(negedge sys_clk);
        `CHK("vec", 4'h4, idx)
        `CHK("lvl", LVL_HIGH, lvl)
        cpu(0);
        `CHK("req", 1'b0, req)
        fire(29'h2);
        `CHK("req", 1'b0, req)
        wr(OFS_LEVEL, 32'h12);
        @(negedge sys_clk);
        `CHK("lvl", LVL_TOP, lvl)
        cpu(0);
        wr(OFS_PEND, 32'h2);
        cpu(1);
        `CHK("req", 1'b0, req)
        cpu(1);
        `CHK("vec", 4'h4, idx)
        wr(OFS_PEND, 32'h1FFFFFFF);
        foreach (srcs[i]) begin
            fire(29'h1 << srcs[i]);
            rd_reg(OFS_PEND);
            `CHK("pend", 32'h1 << srcs[i], rd)
            wr(OFS_PEND, 32'h1 << srcs[i]);
        end
        wr(OFS_FILTER, 32'h0B);
        pin <= 1;
        repeat (20) @(posedge sys_clk);
        rd_reg(OFS_PIN);
        `CHK("pin", 32'h1, rd)
        `CHK("capture", 1'b1, t0cp)
        `CHK("t0 in", 1'b0, tin)
        repeat (140) @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK("t0 in", 1'b1, tin)
        give_verdict();
    end
    // Watchdog: sequence needs under a thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        err_total++;
        give_verdict();
    end
endmodule
